// [rtl/pca_pkg.sv]
// constants, register map and types for the prefetch cache line access block
package pca_pkg;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int LINES = 16;
    localparam int IDX_W = 4;
    localparam int TAG_W = 20;
    localparam int MASK_W = 11;
    localparam int WS_W = 3;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_ACCESS = 8'h04;
    localparam logic [7:0] OFF_TAG = 8'h08;
    localparam logic [7:0] OFF_MASK = 8'h0C;
    localparam logic [7:0] OFF_WORD0 = 8'h10;
    localparam logic [7:0] OFF_WORD1 = 8'h14;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int WS_LSB = 0;
    localparam int WEN_BIT = 31;
    localparam int IDX_LSB = 0;
    localparam int BOOT_BIT = 31;
    localparam int TAG_LSB = 4;
    localparam int VALID_BIT = 3;
    localparam int LOCK_BIT = 2;
    localparam int KIND_BIT = 1;
    localparam int MASK_LSB = 5;
    localparam int ADDR_WSEL_BIT = 2;

    // ------------------------------------------------------------
    // reset values and fixed codes
    // ------------------------------------------------------------
    localparam logic [WS_W-1:0] WS_RESET = 3'h7;
    localparam logic [IDX_W-1:0] IDX_RESET = 4'h0;
    localparam logic KIND_RESET = 1'b1;
    localparam logic [IDX_W-1:0] MASK_LINE_A = 4'hA;
    localparam logic [IDX_W-1:0] MASK_LINE_B = 4'hB;
    // physical address bits 28:24 of the region at 0x1D000000
    localparam logic [4:0] BOOT_REGION_TOP = 5'h1D;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    typedef enum logic [0:0] {
        PCA_IDLE = 1'b0,
        PCA_WAIT = 1'b1
    } pca_state_type;

endpackage

// [rtl/pca_line_access.sv]
// prefetch cache line store with apb line access window and flash wait-state fill
//
// How it works
// RQ1 - each flash access lasts the wait-state field value plus one base cycle.
// RQ2 - tag, mask and word writes land only while line write enable is set.
// RQ3 - the line index picks the line that tag, mask and words reach.
// RQ4 - boot region bit: 1 for the 0x1D000000 area, 0 for 0x1FC00000.
// RQ5 - hit compares stored 20-bit tag against physical address bits 23:4.
// RQ6 - only valid lines can ever produce a hit.
// RQ7 - locked lines are never chosen as the refill victim.
// RQ8 - line kind flag: 1 holds instruction words, 0 holds data words.
// RQ9 - a set mask bit 15..5 forces a match at that address bit.
// RQ10 - mask is writable only for lines 0xA and 0xB, else stays zero.
// RQ11 - word register 0 shows word 0, reads zero when code-protected.
// RQ12 - tag and mask registers follow the currently indexed line.
// RQ13 - software writes zeros to reserved bits and ignores their read value.
// RQ14 - word register 1 shows word 1, reads zero when code-protected.
// RQ15 - hit needs valid set and every unmasked tag bit equal.
//
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module pca_line_access
    import pca_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic code_protect,
    input wire logic fetch_valid,
    input wire logic [31:0] fetch_addr,
    input wire logic fetch_is_instr,
    output logic fetch_ready,
    output logic fetch_done,
    output logic fetch_was_hit,
    output logic [31:0] fetch_rdata,
    output logic flash_req,
    output logic [31:0] flash_addr,
    input wire logic [63:0] flash_rdata
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [IDX_W-1:0] first_set(input logic [LINES-1:0] vec);
        logic [IDX_W-1:0] r;
        r = IDX_RESET;
        for (int k = LINES - 1; k >= 0; k--)
        begin
            if (vec[k])
            begin
                r = IDX_W'(k);
            end
        end
        return r;
    endfunction

    function automatic logic boot_of(input logic [31:0] a);
        return a[28:24] == BOOT_REGION_TOP;
    endfunction

    function automatic logic [TAG_W-1:0] mask_ext(input logic [MASK_W-1:0] m);
        return {8'h00, m, 1'b0};
    endfunction

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [WS_W-1:0] ws_reg;
    logic wen_reg;
    logic [IDX_W-1:0] idx_reg;
    logic [TAG_W-1:0] tag_mem [LINES];
    logic [MASK_W-1:0] mask_mem [LINES];
    logic [31:0] word0_mem [LINES];
    logic [31:0] word1_mem [LINES];
    logic [LINES-1:0] valid_reg;
    logic [LINES-1:0] lock_reg;
    logic [LINES-1:0] kind_reg;
    logic [LINES-1:0] boot_reg;
    logic [IDX_W-1:0] rr_reg;
    pca_state_type state_reg;
    logic [WS_W-1:0] wait_reg;
    logic instr_reg;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic setup;
    logic wr;
    logic mapped;
    logic wr_tag;
    logic wr_mask;
    logic wr_w0;
    logic wr_w1;
    logic mask_ok;
    logic [31:0] tag_word;
    logic [31:0] read_next;

    assign setup = psel && !penable;
    assign wr = psel && penable && pwrite;
    assign mapped = paddr == OFF_CONTROL || paddr == OFF_ACCESS || paddr == OFF_TAG ||
                    paddr == OFF_MASK || paddr == OFF_WORD0 || paddr == OFF_WORD1;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    // RQ2 line write gate
    assign wr_tag = wr && wen_reg && paddr == OFF_TAG;
    assign wr_w0 = wr && wen_reg && paddr == OFF_WORD0;
    assign wr_w1 = wr && wen_reg && paddr == OFF_WORD1;
    // RQ10 mask lines only
    assign mask_ok = idx_reg == MASK_LINE_A || idx_reg == MASK_LINE_B;
    assign wr_mask = wr && wen_reg && mask_ok && paddr == OFF_MASK;

    // RQ12 indexed line view
    always_comb
    begin
        tag_word = ZERO_WORD;
        tag_word[BOOT_BIT] = boot_reg[idx_reg];
        tag_word[TAG_LSB +: TAG_W] = tag_mem[idx_reg];
        tag_word[VALID_BIT] = valid_reg[idx_reg];
        tag_word[LOCK_BIT] = lock_reg[idx_reg];
        tag_word[KIND_BIT] = kind_reg[idx_reg];
    end

    // RQ13 reserved bits read as zero
    always_comb
    begin
        read_next = ZERO_WORD;
        unique case (paddr)
            OFF_CONTROL: read_next[WS_LSB +: WS_W] = ws_reg;
            OFF_ACCESS:
            begin
                read_next[WEN_BIT] = wen_reg;
                read_next[IDX_LSB +: IDX_W] = idx_reg;
            end
            OFF_TAG: read_next = tag_word;
            OFF_MASK: read_next[MASK_LSB +: MASK_W] = mask_mem[idx_reg];
            // RQ11 word zero protected
            OFF_WORD0: read_next = code_protect ? ZERO_WORD : word0_mem[idx_reg];
            // RQ14 word one protected
            OFF_WORD1: read_next = code_protect ? ZERO_WORD : word1_mem[idx_reg];
            default: read_next = ZERO_WORD;
        endcase
    end

    // read data is captured in setup so it stands through the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= ZERO_WORD;
        end
        else if (setup && !pwrite)
        begin
            prdata <= read_next;
        end
    end

    // ------------------------------------------------------------
    // control and access registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ws_reg <= WS_RESET;
            wen_reg <= 1'b0;
            idx_reg <= IDX_RESET;
        end
        else if (wr && paddr == OFF_CONTROL)
        begin
            ws_reg <= pwdata[WS_LSB +: WS_W];
        end
        else if (wr && paddr == OFF_ACCESS)
        begin
            wen_reg <= pwdata[WEN_BIT];
            // RQ3 line select
            idx_reg <= pwdata[IDX_LSB +: IDX_W];
        end
    end

    // ------------------------------------------------------------
    // hit detection
    // ------------------------------------------------------------
    logic [LINES-1:0] hit_vec;
    logic hit_any;
    logic [IDX_W-1:0] hit_idx;

    for (genvar i = 0; i < LINES; i++)
    begin : g_hit
        // RQ15 valid and unmasked tag equal
        assign hit_vec[i] = valid_reg[i] && (boot_reg[i] == boot_of(fetch_addr)) &&
                            (((tag_mem[i] ^ fetch_addr[TAG_LSB +: TAG_W]) & ~mask_ext(mask_mem[i])) == '0);
    end
    assign hit_any = |hit_vec;
    assign hit_idx = first_set(hit_vec);

    // ------------------------------------------------------------
    // victim choice
    // ------------------------------------------------------------
    logic [LINES-1:0] free_vec;
    logic [LINES-1:0] free_rot;
    logic victim_ok;
    logic [IDX_W-1:0] victim;

    // RQ7 locked lines excluded
    assign free_vec = ~lock_reg;
    // rotate so the round-robin pointer sits at bit 0
    assign free_rot = LINES'({free_vec, free_vec} >> rr_reg);
    assign victim_ok = |free_vec;
    assign victim = IDX_W'(first_set(free_rot) + rr_reg);

    // ------------------------------------------------------------
    // fetch and flash sequencing
    // ------------------------------------------------------------
    logic fill;
    logic [31:0] flash_word;

    assign fetch_ready = state_reg == PCA_IDLE;
    assign flash_req = state_reg == PCA_WAIT;
    assign fill = state_reg == PCA_WAIT && wait_reg == '0;
    assign flash_word = flash_addr[ADDR_WSEL_BIT] ? flash_rdata[63:32] : flash_rdata[31:0];

    // RQ1 wait-state count
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= PCA_IDLE;
            wait_reg <= '0;
            flash_addr <= ZERO_WORD;
            instr_reg <= 1'b0;
        end
        else
        begin
            unique case (state_reg)
                PCA_IDLE:
                begin
                    if (fetch_valid && !hit_any)
                    begin
                        state_reg <= PCA_WAIT;
                        wait_reg <= ws_reg;
                        flash_addr <= fetch_addr;
                        instr_reg <= fetch_is_instr;
                    end
                end
                PCA_WAIT:
                begin
                    if (wait_reg == '0)
                    begin
                        state_reg <= PCA_IDLE;
                    end
                    else
                    begin
                        wait_reg <= wait_reg - 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fetch_done <= 1'b0;
            fetch_was_hit <= 1'b0;
            fetch_rdata <= ZERO_WORD;
        end
        else
        begin
            fetch_done <= 1'b0;
            if (fetch_ready && fetch_valid && hit_any)
            begin
                fetch_done <= 1'b1;
                fetch_was_hit <= 1'b1;
                fetch_rdata <= fetch_addr[ADDR_WSEL_BIT] ? word1_mem[hit_idx] : word0_mem[hit_idx];
            end
            else if (fill)
            begin
                fetch_done <= 1'b1;
                fetch_was_hit <= 1'b0;
                fetch_rdata <= flash_word;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rr_reg <= IDX_RESET;
        end
        else if (fill && victim_ok)
        begin
            rr_reg <= IDX_W'(victim + 1'b1);
        end
    end

    // ------------------------------------------------------------
    // line arrays: refill first, software write takes the last word
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            valid_reg <= '0;
            lock_reg <= '0;
            kind_reg <= {LINES{KIND_RESET}};
            boot_reg <= '0;
            for (int k = 0; k < LINES; k++)
            begin
                tag_mem[k] <= '0;
                word0_mem[k] <= ZERO_WORD;
                word1_mem[k] <= ZERO_WORD;
            end
        end
        else
        begin
            if (fill && victim_ok)
            begin
                valid_reg[victim] <= 1'b1;
                // RQ8 kind from fetch type
                kind_reg[victim] <= instr_reg;
                // RQ4 region from address
                boot_reg[victim] <= boot_of(flash_addr);
                // RQ5 tag from address bits 23:4
                tag_mem[victim] <= flash_addr[TAG_LSB +: TAG_W];
                word0_mem[victim] <= flash_rdata[31:0];
                word1_mem[victim] <= flash_rdata[63:32];
            end
            if (wr_tag)
            begin
                boot_reg[idx_reg] <= pwdata[BOOT_BIT];
                tag_mem[idx_reg] <= pwdata[TAG_LSB +: TAG_W];
                // RQ6 valid flag written by software
                valid_reg[idx_reg] <= pwdata[VALID_BIT];
                lock_reg[idx_reg] <= pwdata[LOCK_BIT];
                kind_reg[idx_reg] <= pwdata[KIND_BIT];
            end
            if (wr_w0)
            begin
                word0_mem[idx_reg] <= pwdata;
            end
            if (wr_w1)
            begin
                word1_mem[idx_reg] <= pwdata;
            end
        end
    end

    // RQ9 mask storage
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int k = 0; k < LINES; k++)
            begin
                mask_mem[k] <= '0;
            end
        end
        else if (wr_mask)
        begin
            mask_mem[idx_reg] <= pwdata[MASK_LSB +: MASK_W];
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [3:0] busy_len;
    logic [WS_W-1:0] ws_at_start;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            busy_len <= 4'h0;
            ws_at_start <= '0;
        end
        else if (flash_req)
        begin
            busy_len <= busy_len + 1'b1;
        end
        else
        begin
            busy_len <= 4'h0;
            ws_at_start <= ws_reg;
        end
    end

    wait_state_len_a: assert property ($fell(flash_req) |-> busy_len == 4'(ws_at_start) + 4'h1) // RQ1
        else $error("flash access length differs from wait-state setting");
    wen_blocks_tag_a: assert property (wr && !wen_reg && paddr == OFF_TAG && !fill |=> $stable(tag_word)) // RQ2
        else $error("tag changed while line write disabled");
    index_read_a: assert property (setup && !pwrite && paddr == OFF_TAG |=> prdata == $past(tag_word)) // RQ3
        else $error("tag read not from indexed line");
    fill_region_a: assert property (fill && victim_ok |=> boot_reg[$past(victim)] == boot_of($past(flash_addr))) // RQ4
        else $error("refill region bit wrong");
    hit_needs_valid_a: assert property (hit_any |-> valid_reg[hit_idx]) // RQ6
        else $error("hit on invalid line");
    victim_unlocked_a: assert property (fill && victim_ok |-> !lock_reg[victim]) // RQ7
        else $error("locked line chosen for refill");
    fill_kind_a: assert property (fill && victim_ok |=> kind_reg[$past(victim)] == $past(instr_reg)) // RQ8
        else $error("line kind not set from fetch type");
    hit_compare_a: assert property (hit_any |-> ((tag_mem[hit_idx] ^ fetch_addr[TAG_LSB +: TAG_W])
                                    & ~mask_ext(mask_mem[hit_idx])) == '0) // RQ9
        else $error("hit with unmasked tag mismatch");
    mask_locked_a: assert property (wr && paddr == OFF_MASK && !mask_ok |=> mask_mem[$past(idx_reg)] == '0 ||
                                    $stable(mask_mem[idx_reg])) // RQ10
        else $error("mask written on a line outside 0xA and 0xB");
    word_protect_a: assert property (setup && !pwrite && code_protect &&
                                     (paddr == OFF_WORD0 || paddr == OFF_WORD1) |=> prdata == ZERO_WORD) // RQ11
        else $error("word readable while code-protected");
    hit_answer_a: assert property (fetch_ready && fetch_valid && hit_any |=> fetch_done && fetch_was_hit) // RQ15
        else $error("hit not answered next cycle");

    hit_seen_c: cover property (fetch_ready && fetch_valid && hit_any);
    miss_fill_c: cover property (fill && victim_ok);
    masked_hit_c: cover property (hit_any && mask_mem[hit_idx] != '0);
    long_wait_c: cover property ($fell(flash_req) && ws_at_start == WS_RESET);

endmodule

// [bench/pca_flash_model.sv]
// program flash stand-in answering the line fill port of the cache
`timescale 1ns/1ps
module pca_flash_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic flash_req,
    input wire logic [31:0] flash_addr,
    output logic [63:0] flash_rdata
);
    logic [63:0] last_reg;
    logic [63:0] line_word;

    // words are a plain function of the address so the bench can predict them
    assign line_word = {~flash_addr, flash_addr ^ 32'h5555_0000};
    // a released bus shows the inverse of the last line, never a stale copy
    assign flash_rdata = flash_req ? line_word : ~last_reg;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            last_reg <= 64'h0000_0000_0000_0000;
        else if (flash_req)
            last_reg <= line_word;
    end
endmodule

// [bench/tb.sv]
// self-checking bench for the prefetch cache line access block
`timescale 1ns/1ps
module tb;
    import pca_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, code_protect, fetch_valid, fetch_is_instr;
    logic pready, pslverr, fetch_ready, fetch_done, fetch_was_hit, flash_req, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, fetch_addr, fetch_rdata, flash_addr, rd;
    logic [63:0] flash_rdata;
    int num_errors, samples_checked, nreq, lat, i;

    pca_line_access DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .code_protect(code_protect), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
        .fetch_is_instr(fetch_is_instr), .fetch_ready(fetch_ready), .fetch_done(fetch_done),
        .fetch_was_hit(fetch_was_hit), .fetch_rdata(fetch_rdata), .flash_req(flash_req),
        .flash_addr(flash_addr), .flash_rdata(flash_rdata));

    pca_flash_model flash (.pclk(pclk), .presetn(presetn), .flash_req(flash_req), .flash_addr(flash_addr),
        .flash_rdata(flash_rdata));

    always #50 pclk = ~pclk;

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic test_done();
        if (num_errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (n == 16)
        begin
            num_errors++;
            test_done();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, ZERO_WORD);
        check(rd, exp);
    endtask

    function automatic logic [31:0] acc(input logic w, input logic [3:0] idx);
        return {w, 27'h000_0000, idx};
    endfunction

    // one core request; counts flash cycles and cycles up to the answer
    task automatic fchk(input logic [31:0] a, input logic instr, input logic eh, input logic [31:0] ed,
        input int el, input int en);
        int n;
        fetch_valid <= 1'b1;
        fetch_addr <= a;
        fetch_is_instr <= instr;
        for (n = 0; n < 16; n++)
        begin
            @(negedge pclk);
            if (fetch_ready === 1'b1)
                break;
            @(posedge pclk);
        end
        @(posedge pclk);
        fetch_valid <= 1'b0;
        nreq = 0;
        for (lat = 1; lat < 16; lat++)
        begin
            @(negedge pclk);
            if (flash_req === 1'b1)
                nreq++;
            if (fetch_done === 1'b1)
                break;
        end
        if (n == 16 || lat == 16)
        begin
            num_errors++;
            test_done();
        end
        check({31'h0000_0000, fetch_was_hit}, {31'h0000_0000, eh});
        check(fetch_rdata, ed);
        check(32'(lat), 32'(el));
        check(32'(nreq), 32'(en));
        if (en != 0)
            check(flash_addr, a);
        @(posedge pclk);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = ZERO_WORD;
        code_protect = 1'b0;
        fetch_valid = 1'b0;
        fetch_addr = ZERO_WORD;
        fetch_is_instr = 1'b0;
        num_errors = 0;
        samples_checked = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rchk(OFF_CONTROL, 32'h0000_0007);
        rchk(OFF_ACCESS, ZERO_WORD);
        rchk(OFF_TAG, 32'h0000_0002);
        rchk(OFF_MASK, ZERO_WORD);
        wr(OFF_ACCESS, acc(1'b0, 4'h3));
        wr(OFF_TAG, 32'h8000_123A);
        wr(OFF_WORD0, 32'h1111_2222);
        rchk(OFF_TAG, 32'h0000_0002);
        rchk(OFF_WORD0, ZERO_WORD);
        // lock every line, each with its own tag so the index shows
        for (i = 0; i < 16; i++)
        begin
            wr(OFF_ACCESS, acc(1'b1, i[3:0]));
            wr(OFF_TAG, 32'(i << 4) | 32'h0000_0004);
        end
        for (i = 0; i < 16; i++)
        begin
            wr(OFF_ACCESS, acc(1'b0, i[3:0]));
            rchk(OFF_TAG, 32'(i << 4) | 32'h0000_0004);
        end
        // every wait-state setting, no refill possible while all are locked
        for (i = 0; i < 8; i++)
        begin
            wr(OFF_CONTROL, 32'(i));
            fchk(32'h1D00_4000 + 32'(i << 8), 1'b1, 1'b0, (32'h1D00_4000 + 32'(i << 8)) ^ 32'h5555_0000,
                i + 2, i + 1);
        end
        fchk(32'h1D00_4000, 1'b1, 1'b0, 32'h4855_4000, 9, 8);
        wr(OFF_CONTROL, 32'h0000_0002);
        wr(OFF_ACCESS, acc(1'b1, 4'h3));
        wr(OFF_TAG, 32'h8000_123E);
        wr(OFF_WORD0, 32'h1111_2222);
        wr(OFF_WORD1, 32'h3333_4444);
        rchk(OFF_TAG, 32'h8000_123E);
        rchk(OFF_WORD0, 32'h1111_2222);
        rchk(OFF_WORD1, 32'h3333_4444);
        code_protect <= 1'b1;
        rchk(OFF_WORD0, ZERO_WORD);
        rchk(OFF_WORD1, ZERO_WORD);
        code_protect <= 1'b0;
        fchk(32'h1D00_1230, 1'b1, 1'b1, 32'h1111_2222, 1, 0);
        fchk(32'h1D00_1234, 1'b0, 1'b1, 32'h3333_4444, 1, 0);
        fchk(32'h1FC0_1230, 1'b1, 1'b0, 32'h4A95_1230, 4, 3);
        fchk(32'h1D01_1230, 1'b1, 1'b0, 32'h4854_1230, 4, 3);
        wr(OFF_TAG, 32'h8000_1236);
        fchk(32'h1D00_1230, 1'b1, 1'b0, 32'h4855_1230, 4, 3);
        wr(OFF_MASK, 32'h0000_0200);
        rchk(OFF_MASK, ZERO_WORD);
        // masked tag bit on line 0xA, full mask on line 0xB
        wr(OFF_ACCESS, acc(1'b1, MASK_LINE_A));
        wr(OFF_TAG, 32'h8000_010C);
        wr(OFF_WORD0, 32'hAAAA_5555);
        wr(OFF_MASK, 32'h0000_0200);
        rchk(OFF_MASK, 32'h0000_0200);
        fchk(32'h1D00_0300, 1'b0, 1'b1, 32'hAAAA_5555, 1, 0);
        fchk(32'h1D00_0700, 1'b0, 1'b0, 32'h4855_0700, 4, 3);
        wr(OFF_ACCESS, acc(1'b1, MASK_LINE_B));
        wr(OFF_MASK, 32'h0000_FFE0);
        wr(OFF_ACCESS, acc(1'b0, MASK_LINE_B));
        wr(OFF_MASK, ZERO_WORD);
        rchk(OFF_MASK, 32'h0000_FFE0);
        // line 5 becomes the only refill victim
        wr(OFF_ACCESS, acc(1'b1, 4'h5));
        wr(OFF_TAG, ZERO_WORD);
        fchk(32'h1D00_2000, 1'b1, 1'b0, 32'h4855_2000, 4, 3);
        fchk(32'h1D00_2000, 1'b1, 1'b1, 32'h4855_2000, 1, 0);
        rchk(OFF_TAG, 32'h8000_200A);
        fchk(32'h1D00_3000, 1'b0, 1'b0, 32'h4855_3000, 4, 3);
        rchk(OFF_TAG, 32'h8000_3008);
        rchk(OFF_WORD1, 32'hE2FF_CFFF);
        // miss on the upper word of a line, then a hit on the refilled lower word
        fchk(32'h1D00_4004, 1'b0, 1'b0, 32'hE2FF_BFFB, 4, 3);
        fchk(32'h1D00_4000, 1'b1, 1'b1, 32'h4855_4004, 1, 0);
        apb(1'b0, 8'h18, ZERO_WORD);
        check({31'h0000_0000, er}, 32'h0000_0001);
        check(rd, ZERO_WORD);
        test_done();
    end
endmodule
